// ### hdl/mog_output_gate.sv
`timescale 1ns/1ps
`include "mog_regs.svh"

module mog_output_gate import mog_pkg::*; #(
  parameter int DW = 32,
  parameter int PW = 32
) (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [`MOG_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   sync_trig_in,
  input  wire logic                   aux_trigger_input,
  input  wire logic [PW-1:0]          enc1_pos,
  input  wire logic [PW-1:0]          enc2_pos,
  input  wire logic                   meas_valid,
  input  wire logic [DW-1:0]          meas_data,
  input  wire logic                   meas_ok,
  output logic                        meas_ready,
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic      [DW-1:0]          out_data,
  output logic                        out_err,
  output logic      [`MOG_NIF-1:0]    out_keep,
  output logic      [DW-1:0]          ana_value,
  output logic                        ana_err
);

  // register file
  logic [31:0]               ctrl_reg, ctrl_next;
  logic [`MOG_BURST_W-1:0]   burst_reg, burst_next;
  logic [`MOG_REDUCE_W-1:0]  reduce_reg, reduce_next;
  logic [`MOG_HOLD_W-1:0]    hold_reg, hold_next;
  logic [PW-1:0]             enc_lo_reg, enc_lo_next;
  logic [PW-1:0]             enc_hi_reg, enc_hi_next;
  logic [PW-1:0]             enc_step_reg, enc_step_next;
  logic                      wait_reg, wait_next;
  logic [31:0]               rdata_reg, rdata_next;
  logic                      swtrig_reg, swtrig_next;
  logic                      wr_ok;

  // gating state
  logic                      trig_reg, trig_next;
  logic                      trig_prev_reg, trig_prev_next;
  mog_burst_t                bst_reg, bst_next;
  logic [`MOG_BURST_W-1:0]   rem_reg, rem_next;
  logic [PW-1:0]             enc_pt_reg, enc_pt_next;
  logic [2:0]                mode_prev_reg, mode_prev_next;

  // per-interface reduction and hold tracking
  logic [`MOG_REDUCE_W-1:0]  red_cnt_reg [`MOG_NIF];
  logic [`MOG_REDUCE_W-1:0]  red_cnt_next [`MOG_NIF];
  logic [DW-1:0]             last_reg, last_next;
  logic                      have_last_reg, have_last_next;
  logic [`MOG_HOLD_W-1:0]    bad_cnt_reg, bad_cnt_next;

  // two-entry buffer
  logic                      hv_reg, hv_next, tv_reg, tv_next;
  logic [DW-1:0]             hd_reg, hd_next, td_reg, td_next;
  logic                      he_reg, he_next, te_reg, te_next;
  logic [`MOG_NIF-1:0]       hk_reg, hk_next, tk_reg, tk_next;
  logic                      rdy_reg, rdy_next;
  logic [DW-1:0]             ana_reg, ana_next;
  logic                      anae_reg, anae_next;

  // derived control
  mog_mode_t                 mode;
  mog_hold_t                 hmode;
  logic                      src_sel, pol, inf_cnt, enc_sel;
  logic [`MOG_NIF-1:0]       red_en;
  logic                      trig_pin, edge_hit, enc_hit, start_ev;
  logic                      gate, take, release_v;
  logic [PW-1:0]             enc_pos;
  logic [`MOG_NIF-1:0]       keep;
  logic [DW-1:0]             wdata;
  logic                      werr;
  logic                      push, pop;

  function automatic logic [`MOG_REDUCE_W-1:0] red_step(input logic [`MOG_REDUCE_W-1:0] cnt,
                                                        input logic [`MOG_REDUCE_W-1:0] n);
    logic [`MOG_REDUCE_W-1:0] r;
    r = '0;
    if (n > `MOG_REDUCE_W'(1) && cnt < n - `MOG_REDUCE_W'(1)) begin
      r = cnt + `MOG_REDUCE_W'(1);
    end
    return r;
  endfunction

  assign mode    = mog_mode_t'(ctrl_reg[`MOG_CTRL_MODE_MSB:`MOG_CTRL_MODE_LSB]);
  assign hmode   = mog_hold_t'(ctrl_reg[`MOG_CTRL_HOLD_MSB:`MOG_CTRL_HOLD_LSB]);
  assign src_sel = ctrl_reg[`MOG_CTRL_SRC];
  assign pol     = ctrl_reg[`MOG_CTRL_POL];
  assign inf_cnt = ctrl_reg[`MOG_CTRL_INF];
  assign enc_sel = ctrl_reg[`MOG_CTRL_ENC];
  assign red_en  = ctrl_reg[`MOG_CTRL_RED_MSB:`MOG_CTRL_RED_LSB];
  assign wr_ok   = avs_write && !wait_reg;

  // avalon slave: one wait cycle, access completes at the edge with waitrequest low
  always_comb begin
    ctrl_next     = ctrl_reg;
    burst_next    = burst_reg;
    reduce_next   = reduce_reg;
    hold_next     = hold_reg;
    enc_lo_next   = enc_lo_reg;
    enc_hi_next   = enc_hi_reg;
    enc_step_next = enc_step_reg;
    swtrig_next   = 1'b0;
    rdata_next    = rdata_reg;
    wait_next     = 1'b1;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      case (avs_address)
        `MOG_OFS_CTRL:     rdata_next = ctrl_reg;
        `MOG_OFS_BURST:    rdata_next = 32'(burst_reg);
        `MOG_OFS_REDUCE:   rdata_next = 32'(reduce_reg);
        `MOG_OFS_HOLD:     rdata_next = 32'(hold_reg);
        `MOG_OFS_ENC_LO:   rdata_next = 32'(enc_lo_reg);
        `MOG_OFS_ENC_HI:   rdata_next = 32'(enc_hi_reg);
        `MOG_OFS_ENC_STEP: rdata_next = 32'(enc_step_reg);
        `MOG_OFS_STATUS: begin
          rdata_next = 32'h0000_0000;
          rdata_next[`MOG_ST_GATE] = gate;
          rdata_next[`MOG_ST_BURST] = (bst_reg == MOG_B_RUN);
          rdata_next[`MOG_ST_FULL] = tv_reg;
          rdata_next[`MOG_ST_REM_MSB:`MOG_ST_REM_LSB] = rem_reg;
        end
        default:           rdata_next = 32'h0000_0000;
      endcase
    end
    if (wr_ok) begin
      case (avs_address)
        `MOG_OFS_CTRL:     ctrl_next = avs_writedata & 32'h0000_377f;
        `MOG_OFS_BURST:    burst_next = avs_writedata[`MOG_BURST_W-1:0];
        `MOG_OFS_REDUCE:   reduce_next = avs_writedata[`MOG_REDUCE_W-1:0];
        `MOG_OFS_HOLD:     hold_next = avs_writedata[`MOG_HOLD_W-1:0];
        `MOG_OFS_ENC_LO:   enc_lo_next = avs_writedata[PW-1:0];
        `MOG_OFS_ENC_HI:   enc_hi_next = avs_writedata[PW-1:0];
        `MOG_OFS_ENC_STEP: enc_step_next = avs_writedata[PW-1:0];
        `MOG_OFS_SWTRIG:   swtrig_next = avs_writedata[0];
        default:           swtrig_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg     <= 32'h0000_0000;
      burst_reg    <= `MOG_BURST_RST;
      reduce_reg   <= `MOG_REDUCE_RST;
      hold_reg     <= `MOG_HOLD_RST;
      enc_lo_reg   <= '0;
      enc_hi_reg   <= '0;
      enc_step_reg <= '0;
      swtrig_reg   <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      wait_reg     <= 1'b1;
    end else begin
      ctrl_reg     <= ctrl_next;
      burst_reg    <= burst_next;
      reduce_reg   <= reduce_next;
      hold_reg     <= hold_next;
      enc_lo_reg   <= enc_lo_next;
      enc_hi_reg   <= enc_hi_next;
      enc_step_reg <= enc_step_next;
      swtrig_reg   <= swtrig_next;
      rdata_reg    <= rdata_next;
      wait_reg     <= wait_next;
    end
  end

  // trigger detection works on registered samples, so release trails the trigger
  assign trig_pin = src_sel ? aux_trigger_input : sync_trig_in;
  assign edge_hit = pol ? (trig_reg && !trig_prev_reg) : (!trig_reg && trig_prev_reg);
  assign enc_pos  = enc_sel ? enc2_pos : enc1_pos;
  assign enc_hit  = (enc_pos >= enc_pt_reg) && (enc_pos >= enc_lo_reg) && (enc_pos <= enc_hi_reg);
  assign take     = meas_valid && rdy_reg;

  always_comb begin
    start_ev = 1'b0;
    case (mode)
      MOG_MODE_EDGE: start_ev = edge_hit;
      MOG_MODE_SOFT: start_ev = swtrig_reg;
      MOG_MODE_ENC:  start_ev = enc_hit;
      default:       start_ev = 1'b0;
    endcase
    case (mode)
      MOG_MODE_OFF:   gate = 1'b1;
      MOG_MODE_LEVEL: gate = (trig_reg == pol);
      default:        gate = (bst_reg == MOG_B_RUN);
    endcase
  end

  // gate only picks values; intake rate is untouched
  assign release_v = take && gate;

  always_comb begin
    trig_next      = trig_pin;
    trig_prev_next = trig_reg;
    mode_prev_next = mode;
    bst_next       = bst_reg;
    rem_next       = rem_reg;
    enc_pt_next    = enc_pt_reg;
    if (mode == MOG_MODE_ENC && enc_hit) begin
      enc_pt_next = enc_pt_reg + enc_step_reg;
    end
    if (mode_prev_reg != mode || (mode == MOG_MODE_ENC && enc_pos < enc_lo_reg)) begin
      enc_pt_next = enc_lo_reg;
    end
    case (bst_reg)
      MOG_B_IDLE: begin
        if (start_ev) begin
          bst_next = MOG_B_RUN;
          rem_next = burst_reg;
        end
      end
      MOG_B_RUN: begin
        // new starts ignored while running
        if (release_v && !inf_cnt) begin
          rem_next = rem_reg - `MOG_BURST_W'(1);
          if (rem_reg <= `MOG_BURST_W'(1)) begin
            bst_next = MOG_B_IDLE;
          end
        end
      end
      default: bst_next = MOG_B_IDLE;
    endcase
    if (mode == MOG_MODE_OFF || mode == MOG_MODE_LEVEL || mode_prev_reg != mode) begin
      bst_next = MOG_B_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trig_reg      <= 1'b0;
      trig_prev_reg <= 1'b0;
      mode_prev_reg <= 3'h0;
      bst_reg       <= MOG_B_IDLE;
      rem_reg       <= '0;
      enc_pt_reg    <= '0;
    end else begin
      trig_reg      <= trig_next;
      trig_prev_reg <= trig_prev_next;
      mode_prev_reg <= mode_prev_next;
      bst_reg       <= bst_next;
      rem_reg       <= rem_next;
      enc_pt_reg    <= enc_pt_next;
    end
  end

  // hold tracking runs on every taken value, gated or not
  always_comb begin
    last_next      = last_reg;
    have_last_next = have_last_reg;
    bad_cnt_next   = bad_cnt_reg;
    wdata          = meas_data;
    werr           = 1'b0;
    if (!meas_ok) begin
      wdata = last_reg;
      case (hmode)
        MOG_HOLD_INF: werr = !have_last_reg;
        MOG_HOLD_CNT: werr = !have_last_reg ||
                             (hold_reg != `MOG_HOLD_W'(0) && bad_cnt_reg >= hold_reg);
        default:      werr = 1'b1;
      endcase
      if (werr) begin
        wdata = '0;
      end
    end
    if (take) begin
      if (meas_ok) begin
        last_next      = meas_data;
        have_last_next = 1'b1;
        bad_cnt_next   = '0;
      end else if (bad_cnt_reg != {`MOG_HOLD_W{1'b1}}) begin
        bad_cnt_next = bad_cnt_reg + `MOG_HOLD_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_reg      <= '0;
      have_last_reg <= 1'b0;
      bad_cnt_reg   <= '0;
    end else begin
      last_reg      <= last_next;
      have_last_reg <= have_last_next;
      bad_cnt_reg   <= bad_cnt_next;
    end
  end

  // every nth released value per enabled interface
  always_comb begin
    for (int i = 0; i < `MOG_NIF; i++) begin
      keep[i]         = !red_en[i] || (red_cnt_reg[i] == '0);
      red_cnt_next[i] = red_cnt_reg[i];
      if (release_v && red_en[i]) begin
        red_cnt_next[i] = red_step(red_cnt_reg[i], reduce_reg);
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < `MOG_NIF; i++) begin
      if (sys_rst) begin
        red_cnt_reg[i] <= '0;
      end else begin
        red_cnt_reg[i] <= red_cnt_next[i];
      end
    end
  end

  // two-entry buffer; values land at least one cycle after being taken
  assign push = release_v && (keep != '0);
  assign pop  = hv_reg && out_ready;

  always_comb begin
    hv_next   = hv_reg;
    hd_next   = hd_reg;
    he_next   = he_reg;
    hk_next   = hk_reg;
    tv_next   = tv_reg;
    td_next   = td_reg;
    te_next   = te_reg;
    tk_next   = tk_reg;
    ana_next  = ana_reg;
    anae_next = anae_reg;
    if (pop) begin
      hv_next = tv_reg;
      hd_next = td_reg;
      he_next = te_reg;
      hk_next = tk_reg;
      tv_next = 1'b0;
      if (hk_reg[`MOG_IF_ANALOG]) begin
        ana_next  = hd_reg;
        anae_next = he_reg;
      end
    end
    if (push) begin
      if (!hv_next) begin
        hv_next = 1'b1;
        hd_next = wdata;
        he_next = werr;
        hk_next = keep;
      end else begin
        tv_next = 1'b1;
        td_next = wdata;
        te_next = werr;
        tk_next = keep;
      end
    end
    rdy_next = !tv_next;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hv_reg   <= 1'b0;
      hd_reg   <= '0;
      he_reg   <= 1'b0;
      hk_reg   <= '0;
      tv_reg   <= 1'b0;
      td_reg   <= '0;
      te_reg   <= 1'b0;
      tk_reg   <= '0;
      rdy_reg  <= 1'b1;
      ana_reg  <= '0;
      anae_reg <= 1'b0;
    end else begin
      hv_reg   <= hv_next;
      hd_reg   <= hd_next;
      he_reg   <= he_next;
      hk_reg   <= hk_next;
      tv_reg   <= tv_next;
      td_reg   <= td_next;
      te_reg   <= te_next;
      tk_reg   <= tk_next;
      rdy_reg  <= rdy_next;
      ana_reg  <= ana_next;
      anae_reg <= anae_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign meas_ready      = rdy_reg;
  assign out_valid       = hv_reg;
  assign out_data        = hd_reg;
  assign out_err         = he_reg;
  assign out_keep        = hk_reg;
  assign ana_value       = ana_reg;
  assign ana_err         = anae_reg;

endmodule

// ### include/mog_regs.svh
// Function
// - release of values to analog and digital outputs is gated by trigger input or command
// - a triggered value leaves the block at least one cycle after its trigger instant
// - trigger modes never change the measuring rate, they only select released values
// - after reset triggering is off and values flow out continuously
// - level mode releases values while selected input sits at the chosen level
// - edge mode starts release on the chosen edge of the selected input
// - each edge seen while no burst runs releases a programmed count of 1 to 16383 values, or unlimited
// - after a burst ends the analog output holds the last released value
// - software mode starts release on a software trigger command
// - encoder mode starts release from encoder position with lower, upper limit and step
// - inactive triggering releases every measured value without gating
// - measurement intake and hold tracking run regardless of trigger state
// - reduction n forwards only every nth value, n from 1 to 3,000,000
// - reduction applies only to interfaces whose enable bit is set
// - error mode sends an error marker instead of a value when reading invalid
// - hold-forever mode repeats last valid value until a new valid one arrives
// - counted hold repeats last valid value up to N times, 0 holds forever
`ifndef MOG_REGS_SVH
`define MOG_REGS_SVH

`define MOG_ADDR_W          6
`define MOG_OFS_CTRL        6'h00
`define MOG_OFS_BURST       6'h04
`define MOG_OFS_REDUCE      6'h08
`define MOG_OFS_HOLD        6'h0c
`define MOG_OFS_ENC_LO      6'h10
`define MOG_OFS_ENC_HI      6'h14
`define MOG_OFS_ENC_STEP    6'h18
`define MOG_OFS_SWTRIG      6'h1c
`define MOG_OFS_STATUS      6'h20

`define MOG_CTRL_MODE_LSB   0
`define MOG_CTRL_MODE_MSB   2
`define MOG_CTRL_SRC        3
`define MOG_CTRL_POL        4
`define MOG_CTRL_INF        5
`define MOG_CTRL_ENC        6
`define MOG_CTRL_RED_LSB    8
`define MOG_CTRL_RED_MSB    10
`define MOG_CTRL_HOLD_LSB   12
`define MOG_CTRL_HOLD_MSB   13

`define MOG_ST_GATE         0
`define MOG_ST_BURST        1
`define MOG_ST_FULL         2
`define MOG_ST_REM_LSB      16
`define MOG_ST_REM_MSB      29

`define MOG_BURST_W         14
`define MOG_REDUCE_W        22
`define MOG_HOLD_W          11
`define MOG_BURST_RST       14'h0001
`define MOG_REDUCE_RST      22'h000001
`define MOG_HOLD_RST        11'h000
`define MOG_NIF             3
`define MOG_IF_RS422        0
`define MOG_IF_ANALOG       1
`define MOG_IF_ETH          2

`endif

// ### include/mog_pkg.sv
package mog_pkg;

  typedef enum logic [2:0] {
    MOG_MODE_OFF   = 3'b000,
    MOG_MODE_LEVEL = 3'b001,
    MOG_MODE_EDGE  = 3'b010,
    MOG_MODE_SOFT  = 3'b011,
    MOG_MODE_ENC   = 3'b100
  } mog_mode_t;

  typedef enum logic [1:0] {
    MOG_HOLD_ERR   = 2'b00,
    MOG_HOLD_INF   = 2'b01,
    MOG_HOLD_CNT   = 2'b10
  } mog_hold_t;

  typedef enum logic [0:0] {
    MOG_B_IDLE     = 1'b0,
    MOG_B_RUN      = 1'b1
  } mog_burst_t;

endpackage

// ### verif/mog_gate_props.sv
`timescale 1ns/1ps
module mog_gate_props #(
  parameter int DW = 32
) (
  input wire logic          clk,
  input wire logic          sys_rst,
  input wire logic          avs_read,
  input wire logic          avs_write,
  input wire logic          avs_waitrequest,
  input wire logic          meas_valid,
  input wire logic          meas_ready,
  input wire logic          out_valid,
  input wire logic          out_ready,
  input wire logic [DW-1:0] out_data,
  input wire logic          out_err,
  input wire logic [2:0]    out_keep,
  input wire logic [DW-1:0] ana_value,
  input wire logic          ana_err
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait state");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without request");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_keep))
    else $error("stalled output word changed");
  err_zero_a: assert property (out_valid && out_err |-> out_data == '0)
    else $error("error word carries data");
  keep_set_a: assert property (out_valid |-> out_keep != 3'h0)
    else $error("word pushed with no interface");
  out_late_a: assert property ($rose(out_valid) |-> $past(meas_valid && meas_ready))
    else $error("output appeared without a taken value");
  ana_take_a: assert property (out_valid && out_ready && out_keep[1] |=> ana_value == $past(out_data)
    && ana_err == $past(out_err))
    else $error("analog output missed popped word");
  ana_keep_a: assert property (!(out_valid && out_ready && out_keep[1]) |=> $stable(ana_value))
    else $error("analog output moved without a word");
  intake_a: assert property (!meas_ready |-> out_valid)
    else $error("intake refused with empty buffer");
endmodule

bind mog_output_gate mog_gate_props #(.DW(DW)) u_props (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .meas_valid(meas_valid), .meas_ready(meas_ready),
  .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_err(out_err), .out_keep(out_keep),
  .ana_value(ana_value), .ana_err(ana_err));

// ### verif/mog_out_sink.sv
`timescale 1ns/1ps
module mog_out_sink (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic slow,
  output logic     out_ready
);
  logic tog_reg;
  // slow consumer takes every other cycle
  always_ff @(posedge clk) begin
    tog_reg <= sys_rst ? 1'b0 : !tog_reg;
  end
  assign out_ready = !stall && (!slow || tog_reg);
endmodule

// ### verif/test_measurement_output_gating.sv
`timescale 1ns/1ps
`include "mog_regs.svh"
module test_measurement_output_gating import mog_pkg::*; ;
  typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e;} mog_row_t;
  logic        clk, sys_rst, avs_read, avs_write, avs_waitrequest, sync_trig_in, aux_trigger_input;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, enc1_pos, enc2_pos, meas_data, out_data, ana_value, q;
  logic        meas_valid, meas_ok, meas_ready, out_valid, out_ready, out_err, ana_err, stall, slow;
  logic [2:0]  out_keep;
  logic [35:0] got[$];
  mog_row_t    rows[6];
  int          n_fail, cmp_count, cyc;

  mog_output_gate u_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sync_trig_in(sync_trig_in), .aux_trigger_input(aux_trigger_input),
    .enc1_pos(enc1_pos), .enc2_pos(enc2_pos), .meas_valid(meas_valid), .meas_data(meas_data), .meas_ok(meas_ok),
    .meas_ready(meas_ready), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_err(out_err), .out_keep(out_keep), .ana_value(ana_value), .ana_err(ana_err));
  mog_out_sink u_sink (.clk(clk), .sys_rst(sys_rst), .stall(stall), .slow(slow), .out_ready(out_ready));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (!sys_rst && out_valid && out_ready) got.push_back({out_err, out_keep, out_data});
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    // waitrequest read here is its value at this edge
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic send(input int n, input logic [31:0] base, input logic ok);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      meas_valid <= 1'b1;
      meas_data  <= base + 32'(i);
      meas_ok    <= ok;
      do @(posedge clk); while (meas_ready !== 1'b1);
      meas_valid <= 1'b0;
    end
  endtask

  // checks collected words against a run of data, then clears
  task automatic expq(input int n, input logic [31:0] base, input string s);
    repeat (8) @(posedge clk);
    chk(36'(got.size()), 36'(n));
    foreach (got[i]) chk(got[i], {1'b0, 3'h7, base + 32'(i)});
    got.delete();
    $display("end of test %s", s);
  endtask

  task automatic pulse();
    @(posedge clk);
    aux_trigger_input <= 1'b1;
    repeat (2) @(posedge clk);
    aux_trigger_input <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    {sys_rst, avs_read, avs_write, sync_trig_in, aux_trigger_input, meas_valid, stall, slow} = 8'h80;
    {avs_address, avs_writedata, enc1_pos, enc2_pos, meas_data, meas_ok} = '0;
    rows[0] = '{`MOG_OFS_CTRL, 32'hfffffffc, 32'h0000377c};
    rows[1] = '{`MOG_OFS_BURST, 32'hffffffff, 32'h00003fff};
    rows[2] = '{`MOG_OFS_REDUCE, 32'hffffffff, 32'h003fffff};
    rows[3] = '{`MOG_OFS_HOLD, 32'hffffffff, 32'h000007ff};
    rows[4] = '{`MOG_OFS_SWTRIG, 32'h00000000, 32'h00000000};
    rows[5] = '{6'h24, 32'h12345678, 32'h00000000};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      chk(36'(q), 36'(rows[i].e));
    end
    $display("end of test registers");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 6'(4 * i), 32'h0);
      chk(36'(q), (i == 1 || i == 2) ? 36'h1 : 36'h0);
    end
    send(3, 32'h100, 1'b1);
    expq(3, 32'h100, "reset flow");
    bus(1'b1, `MOG_OFS_CTRL, {27'h0, 2'b10, MOG_MODE_LEVEL});
    send(2, 32'h200, 1'b1);
    sync_trig_in <= 1'b1;
    repeat (3) @(posedge clk);
    send(2, 32'h210, 1'b1);
    sync_trig_in <= 1'b0;
    repeat (3) @(posedge clk);
    send(2, 32'h220, 1'b1);
    expq(2, 32'h210, "level");
    bus(1'b1, `MOG_OFS_BURST, 32'h3);
    bus(1'b1, `MOG_OFS_CTRL, {27'h0, 2'b11, MOG_MODE_EDGE});
    pulse();
    send(1, 32'h300, 1'b1);
    pulse();
    send(5, 32'h301, 1'b1);
    chk(36'(ana_value), 36'h302);
    expq(3, 32'h300, "edge burst");
    bus(1'b1, `MOG_OFS_CTRL, {26'h0, 3'b111, MOG_MODE_EDGE});
    pulse();
    send(5, 32'h380, 1'b1);
    expq(5, 32'h380, "edge unlimited");
    bus(1'b1, `MOG_OFS_BURST, 32'h2);
    bus(1'b1, `MOG_OFS_CTRL, {29'h0, MOG_MODE_SOFT});
    bus(1'b1, `MOG_OFS_SWTRIG, 32'h1);
    repeat (3) @(posedge clk);
    send(4, 32'h400, 1'b1);
    expq(2, 32'h400, "software");
    sync_trig_in <= 1'b1;
    bus(1'b1, `MOG_OFS_CTRL, {29'h0, MOG_MODE_EDGE});
    sync_trig_in <= 1'b0;
    repeat (3) @(posedge clk);
    send(3, 32'h480, 1'b1);
    expq(2, 32'h480, "falling edge");
    bus(1'b1, `MOG_OFS_ENC_LO, 32'd10);
    bus(1'b1, `MOG_OFS_ENC_HI, 32'd100);
    bus(1'b1, `MOG_OFS_ENC_STEP, 32'd10);
    enc1_pos <= 32'd5;
    bus(1'b1, `MOG_OFS_CTRL, {29'h0, MOG_MODE_ENC});
    send(2, 32'h500, 1'b1);
    enc1_pos <= 32'd10;
    repeat (3) @(posedge clk);
    send(3, 32'h510, 1'b1);
    expq(2, 32'h510, "encoder");
    enc2_pos <= 32'd20;
    bus(1'b1, `MOG_OFS_CTRL, {25'h0, 1'b1, 3'h0, MOG_MODE_ENC});
    send(3, 32'h520, 1'b1);
    expq(2, 32'h520, "encoder two");
    bus(1'b1, `MOG_OFS_REDUCE, 32'h3);
    bus(1'b1, `MOG_OFS_CTRL, 32'h00000100);
    send(6, 32'h600, 1'b1);
    repeat (8) @(posedge clk);
    chk(36'(got.size()), 36'h6);
    foreach (got[i]) chk(got[i], {1'b0, (i % 3 == 0) ? 3'h7 : 3'h6, 32'h600 + 32'(i)});
    got.delete();
    bus(1'b1, `MOG_OFS_CTRL, 32'h0);
    send(1, 32'h700, 1'b0);
    bus(1'b1, `MOG_OFS_CTRL, 32'h00001000);
    send(1, 32'h710, 1'b1);
    send(2, 32'h7ee, 1'b0);
    bus(1'b1, `MOG_OFS_CTRL, 32'h00002000);
    bus(1'b1, `MOG_OFS_HOLD, 32'h2);
    send(1, 32'h720, 1'b1);
    send(3, 32'h7ee, 1'b0);
    repeat (8) @(posedge clk);
    chk(36'(got.size()), 36'h8);
    chk(got[0], {1'b1, 3'h7, 32'h0});
    chk(got[2], {1'b0, 3'h7, 32'h710});
    chk(got[3], {1'b0, 3'h7, 32'h710});
    chk(got[6], {1'b0, 3'h7, 32'h720});
    chk(got[7], {1'b1, 3'h7, 32'h0});
    got.delete();
    bus(1'b1, `MOG_OFS_HOLD, 32'h0);
    send(1, 32'h730, 1'b1);
    send(3, 32'h7ee, 1'b0);
    repeat (8) @(posedge clk);
    chk(36'(got.size()), 36'h4);
    foreach (got[i]) chk(got[i], {1'b0, 3'h7, 32'h730});
    got.delete();
    $display("end of test error handling");
    bus(1'b1, `MOG_OFS_CTRL, 32'h0);
    stall <= 1'b1;
    send(2, 32'h800, 1'b1);
    @(posedge clk);
    chk(36'({meas_ready, out_valid}), 36'h1);
    stall <= 1'b0;
    slow <= 1'b1;
    send(4, 32'h802, 1'b1);
    expq(6, 32'h800, "buffer stall");
    wrap_up();
  end
endmodule
